// >>> lasp_host.sv
// Host controller driving a latched-address 18-bit asynchronous static RAM.
// Assumes request inputs synchronous to clk and the memory wired to the pin ports.
`timescale 1ns/1ps

// Overview of operation
// - Address and enable stable around capture fall
// - Write data stable around data capture fall
// - Host may hold both captures high
// - Byte strobes high during every read
// - Address valid by chip enable fall
// - Byte strobes high when address changes
module lasp_host #(
	parameter bit USE_LATCH = 1'b1 // Zero keeps both captures high, fully asynchronous
) (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic                       req_valid,      // Start an access
	input  wire logic                       req_write,      // One for write
	input  wire logic [lasp_pkg::ADDR_W-1:0] req_addr,      // Word address
	input  wire logic [lasp_pkg::DATA_W-1:0] req_wdata,     // Write word
	input  wire logic [1:0]                 req_byte_en,    // Bit0 lower lane, bit1 upper
	output logic                            req_ready,      // Idle, may take a request
	output logic                            rsp_valid,      // One-cycle completion pulse
	output logic [lasp_pkg::DATA_W-1:0]      rsp_rdata,     // Read word
	output logic [lasp_pkg::ADDR_W-1:0]      mem_addr,      // Address pins
	output logic                            mem_chip_en_n,  // Chip enable, low active
	output logic                            mem_out_en_n,   // Output enable, low active
	output logic                            addr_capture,   // Address latch strobe
	output logic                            din_capture,    // Data latch strobe
	output logic                            lower_byte_wr_n, // Lower lane write strobe
	output logic                            upper_byte_wr_n, // Upper lane write strobe
	input  wire logic [lasp_pkg::DATA_W-1:0] mem_dq_in,     // Data pins as seen
	output logic [lasp_pkg::DATA_W-1:0]      mem_dq_out,    // Data driven to pins
	output logic                            mem_dq_oe       // High while host drives pins
);

	// ****************************************************************
	// State record
	// ****************************************************************
	typedef struct packed {
		lasp_pkg::lasp_state_type      st;     // Sequencer state
		logic [1:0]                    cnt;    // Cycles left in phase
		logic                          wr;     // Access is a write
		logic [1:0]                    ben;    // Byte enables of access
		logic                          rdy;    // Ready output
		logic                          rsp;    // Completion pulse
		logic [lasp_pkg::DATA_W-1:0]   rdata;  // Captured read data
		logic [lasp_pkg::ADDR_W-1:0]   addr;   // Address pins
		logic                          ce_n;   // Chip enable
		logic                          oe_n;   // Output enable
		logic                          acap;   // Address capture strobe
		logic                          dcap;   // Data capture strobe
		logic                          lo_wr_n; // Lower lane strobe
		logic                          up_wr_n; // Upper lane strobe
		logic [lasp_pkg::DATA_W-1:0]   dout;   // Write data
		logic                          doe;    // Drive enable
	} lasp_regs_type;

	lasp_regs_type s_reg;  // Registered state
	lasp_regs_type s_next; // Next state

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Each access: present address with chip enable high, drop chip
	// enable, then lower the captures and strobe or read on the same edge.
	always_comb begin
		s_next = s_reg;
		s_next.rsp = 1'b0;
		unique case (s_reg.st)
			lasp_pkg::ST_IDLE: begin
				// Everything parked: deselected, strobes high, bus released
				s_next.rdy = 1'b1;
				// Taken only while ready, so the first edge after reset takes nothing
				if (req_valid && s_reg.rdy) begin
					s_next.rdy   = 1'b0;
					s_next.wr    = req_write;
					s_next.ben   = req_write ? req_byte_en : 2'h0;
					s_next.addr  = req_addr;   // Address changes only with strobes high
					s_next.dout  = req_wdata;
					s_next.doe   = req_write;  // Reads never drive the pins
					s_next.st    = lasp_pkg::ST_SETUP;
				end
			end
			lasp_pkg::ST_SETUP: begin
				// Address already stable a cycle before enable falls
				s_next.ce_n = 1'b0;
				s_next.st   = lasp_pkg::ST_LATCH;
			end
			lasp_pkg::ST_LATCH: begin
				// Address, enable and data held a cycle before and after the fall
				// With latching off both captures stay high
				s_next.acap = ~USE_LATCH;
				s_next.dcap = ~(USE_LATCH & s_reg.wr);
				s_next.cnt  = s_reg.wr ? 2'(lasp_pkg::WPULSE_CYC) : 2'(lasp_pkg::ACCESS_CYC);
				if (s_reg.wr) begin
					// Per-lane strobes select bytes
					s_next.lo_wr_n = ~s_reg.ben[0];
					s_next.up_wr_n = ~s_reg.ben[1];
					s_next.st   = lasp_pkg::ST_WRITE;
				end else begin
					// Read: byte strobes stay high, memory may drive
					s_next.oe_n = 1'b0;
					s_next.st   = lasp_pkg::ST_READ;
				end
			end
			lasp_pkg::ST_WRITE: begin
				// Write pulse spans the enable and strobe overlap
				if (s_reg.cnt == lasp_pkg::CNT_ONE) begin
					s_next.lo_wr_n = 1'b1;
					s_next.up_wr_n = 1'b1;
					s_next.st   = lasp_pkg::ST_END;
				end else begin
					s_next.cnt = s_reg.cnt - 2'h1;
				end
			end
			lasp_pkg::ST_READ: begin
				// Sample once the access time has surely passed
				if (s_reg.cnt == lasp_pkg::CNT_ONE) begin
					s_next.rdata = mem_dq_in;
					s_next.oe_n  = 1'b1;
					s_next.st    = lasp_pkg::ST_END;
				end else begin
					s_next.cnt = s_reg.cnt - 2'h1;
				end
			end
			lasp_pkg::ST_END: begin
				// Strobes high first, then deselect and reopen the latches
				s_next.ce_n = 1'b1;
				s_next.acap = 1'b1;
				s_next.dcap = 1'b1;
				s_next.doe  = 1'b0;
				s_next.rsp  = 1'b1;
				s_next.rdy  = 1'b1;
				s_next.st   = lasp_pkg::ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset parks the memory deselected with the bus released
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg       <= '0;
			s_reg.st    <= lasp_pkg::ST_IDLE;
			s_reg.ce_n  <= 1'b1;
			s_reg.oe_n  <= 1'b1;
			s_reg.acap  <= 1'b1;
			s_reg.dcap  <= 1'b1;
			s_reg.lo_wr_n <= 1'b1;
			s_reg.up_wr_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flip-flops
	assign req_ready       = s_reg.rdy;
	assign rsp_valid       = s_reg.rsp;
	assign rsp_rdata       = s_reg.rdata;
	assign mem_addr        = s_reg.addr;
	assign mem_chip_en_n   = s_reg.ce_n;
	assign mem_out_en_n    = s_reg.oe_n;
	assign addr_capture    = s_reg.acap;
	assign din_capture     = s_reg.dcap;
	assign lower_byte_wr_n = s_reg.lo_wr_n;
	assign upper_byte_wr_n = s_reg.up_wr_n;
	assign mem_dq_out      = s_reg.dout;
	assign mem_dq_oe       = s_reg.doe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_rd_no_wr;
		@(posedge clk) disable iff (!nrst)
		!mem_out_en_n |-> (lower_byte_wr_n && upper_byte_wr_n && !mem_dq_oe);
	endproperty
	a_rd_no_wr: assert property (p_rd_no_wr) else $error("byte strobe low during read");

	property p_addr_stable;
		@(posedge clk) disable iff (!nrst)
		!$stable(mem_addr) |-> (lower_byte_wr_n && upper_byte_wr_n && mem_chip_en_n);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved during access");

	property p_ce_addr;
		@(posedge clk) disable iff (!nrst)
		$fell(mem_chip_en_n) |-> $stable(mem_addr);
	endproperty
	a_ce_addr: assert property (p_ce_addr) else $error("address late at enable fall");

	property p_cap_hold;
		@(posedge clk) disable iff (!nrst)
		$fell(addr_capture) |-> ##1 ($stable(mem_addr) && !mem_chip_en_n);
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("address not held after capture");

	property p_din_hold;
		@(posedge clk) disable iff (!nrst)
		$fell(din_capture) |-> ($stable(mem_dq_out) && mem_dq_oe) ##1 $stable(mem_dq_out);
	endproperty
	a_din_hold: assert property (p_din_hold) else $error("write data not held at capture");

	property p_wr_overlap;
		@(posedge clk) disable iff (!nrst)
		(!lower_byte_wr_n || !upper_byte_wr_n) |-> (!mem_chip_en_n && mem_dq_oe);
	endproperty
	a_wr_overlap: assert property (p_wr_overlap) else $error("write strobe outside enable");

	property p_lane_map;
		@(posedge clk) disable iff (!nrst)
		(req_valid && req_ready && req_write) |-> ##3
		(lower_byte_wr_n == !$past(req_byte_en[0], 3) && upper_byte_wr_n == !$past(req_byte_en[1], 3));
	endproperty
	a_lane_map: assert property (p_lane_map) else $error("wrong byte lane strobed");

	property p_async_mode;
		@(posedge clk) disable iff (!nrst)
		!USE_LATCH |-> (addr_capture && din_capture);
	endproperty
	a_async_mode: assert property (p_async_mode) else $error("capture lowered in async mode");

	property p_deselect;
		@(posedge clk) disable iff (!nrst)
		mem_chip_en_n |-> (mem_out_en_n && lower_byte_wr_n && upper_byte_wr_n);
	endproperty
	a_deselect: assert property (p_deselect) else $error("control active while deselected");

	property p_done;
		@(posedge clk) disable iff (!nrst)
		(req_valid && req_ready) |-> ##[4:5] rsp_valid;
	endproperty
	a_done: assert property (p_done) else $error("access did not complete");

endmodule

// >>> lasp_pkg.sv
// Package for the host-side controller of a latched-address 18-bit static RAM.
// Assumes a 50 MHz system clock; all pin timing is expressed in whole cycles.
package lasp_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 16;   // Word address width
	localparam int DATA_W = 18;   // Word width, two 9-bit bytes
	localparam int LANE_W = 9;    // Byte lane width
	localparam int LO_MSB = 8;    // Lower lane top bit
	localparam int UP_LSB = 9;    // Upper lane bottom bit

	// ****************************************************************
	// Timing, in clock cycles at 20 ns
	// ****************************************************************
	localparam int CLK_NS      = 20;                          // Clock period
	localparam int ACCESS_NS   = 15;                          // Slowest access time
	localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS; // Least time rounds up
	localparam int WPULSE_NS   = 13;                          // Slowest write pulse
	localparam int WPULSE_CYC  = (WPULSE_NS + CLK_NS - 1) / CLK_NS; // Least time rounds up
	localparam logic [1:0] CNT_ONE = 2'h1;                    // Counter value in the last cycle of a phase

	// ****************************************************************
	// Sequencer states, one-hot
	// ****************************************************************
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01, // Deselected, bus released
		ST_SETUP = 6'h02, // Address and enable presented
		ST_LATCH = 6'h04, // Latch strobes lowered
		ST_WRITE = 6'h08, // Byte strobes low
		ST_READ  = 6'h10, // Output enable low, waiting access
		ST_END   = 6'h20  // Strobes raised, deselect
	} lasp_state_type;

endpackage

// >>> lasp_sram_model.sv
// Behavioural model of the latched-address 18-bit static RAM.
// Assumes host pins as inputs; the bench resolves the shared data bus.
`timescale 1ns/1ps
module lasp_sram_model (
	input  wire logic [15:0] addr,            // Address pins
	input  wire logic        chip_en_n,       // Chip enable
	input  wire logic        out_en_n,        // Output enable
	input  wire logic        addr_capture,    // Address latch strobe
	input  wire logic        din_capture,     // Data latch strobe
	input  wire logic        lower_byte_wr_n, // Lower lane strobe
	input  wire logic        upper_byte_wr_n, // Upper lane strobe
	input  wire logic [17:0] dq_in,           // Bus as seen
	output logic      [17:0] dq_out,          // Stored word
	output logic             dq_drive         // High while driving
);
	// ****************************************************************
	// Latches and core
	// ****************************************************************
	logic [17:0] mem_reg [0:65535];  // Core array
	logic [15:0] addr_lat;           // Address latch
	logic [17:0] din_lat;            // Data latch
	logic        ce_lat_n = 1'b1;    // Deselected at power up
	// Transparent while strobe high, frozen by its fall
	always @* if (addr_capture) begin
		addr_lat = addr;
		ce_lat_n = chip_en_n;
	end
	// Data latch, same scheme
	always @* if (din_capture) din_lat = dq_in;
	// Per-lane write only in enable and strobe overlap
	always @* begin
		if (!ce_lat_n && !lower_byte_wr_n) mem_reg[addr_lat][8:0] = din_lat[8:0];
		if (!ce_lat_n && !upper_byte_wr_n) mem_reg[addr_lat][17:9] = din_lat[17:9];
	end
	assign dq_out = mem_reg[addr_lat];
	// Drives only in a read with output enable low
	assign dq_drive = !ce_lat_n && !out_en_n && lower_byte_wr_n && upper_byte_wr_n;
endmodule

// >>> latched_addr_sram_port_test.sv
// Self-checking bench for the latched-address SRAM host controller.
// Assumes lasp_pkg compiled first; the memory model sits on the pins.
`timescale 1ns/1ps
module latched_addr_sram_port_test;
	logic        clk = 1'b0;       // 50 MHz clock
	logic        nrst = 1'b0;      // Reset, low active
	logic        req_valid = 1'b0; // Request
	logic        req_write = 1'b0; // Write select
	logic [15:0] req_addr = 16'h0; // Address
	logic [17:0] req_wdata = 18'h0; // Write word
	logic [1:0]  req_byte_en = 2'h0; // Lane enables
	logic        req_ready, rsp_valid, ce_n, oe_n, acap, dcap, lo_wr_n, up_wr_n, dq_oe, drv;
	logic        as_ready, as_rsp, as_ce_n, as_oe_n, as_acap, as_dcap, as_lo_n, as_up_n, as_oe, as_drv; // Async pair
	logic [17:0] as_rdata, as_dout, as_q, as_last, as_bus; // Async pair data
	logic [15:0] as_addr;           // Async pair address
	logic [17:0] rsp_rdata, dq_out, sram_q, last_dq, dq_bus, rd;
	logic [15:0] mem_addr, p_addr; // Pins, last sample
	logic        p_ce, p_acap, p_dcap; // Last samples
	logic [17:0] p_dq;              // Last driven word
	int          bad_count = 0;     // Mismatches
	int          num_checks = 0;    // Comparisons
	always #10 clk = ~clk;
	// Released bus shows inverse of last value, not a stale copy
	assign dq_bus = dq_oe ? dq_out : (drv ? sram_q : ~last_dq);
	always @(posedge clk) last_dq <= dq_bus;
	// Same bus scheme for the pair with latching off
	assign as_bus = as_oe ? as_dout : (as_drv ? as_q : ~as_last);
	always @(posedge clk) as_last <= as_bus;
	lasp_host lasp_host_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_chip_en_n(ce_n),
		.mem_out_en_n(oe_n), .addr_capture(acap), .din_capture(dcap), .lower_byte_wr_n(lo_wr_n),
		.upper_byte_wr_n(up_wr_n), .mem_dq_in(dq_bus), .mem_dq_out(dq_out), .mem_dq_oe(dq_oe));
	lasp_sram_model lasp_sram_model_inst (.addr(mem_addr), .chip_en_n(ce_n), .out_en_n(oe_n),
		.addr_capture(acap), .din_capture(dcap), .lower_byte_wr_n(lo_wr_n), .upper_byte_wr_n(up_wr_n),
		.dq_in(dq_bus), .dq_out(sram_q), .dq_drive(drv));
	// Second pair runs with latching off, so every latch stays transparent
	lasp_host #(.USE_LATCH(1'b0)) lasp_host_async_inst (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
		.req_ready(as_ready), .rsp_valid(as_rsp), .rsp_rdata(as_rdata), .mem_addr(as_addr),
		.mem_chip_en_n(as_ce_n), .mem_out_en_n(as_oe_n), .addr_capture(as_acap), .din_capture(as_dcap),
		.lower_byte_wr_n(as_lo_n), .upper_byte_wr_n(as_up_n), .mem_dq_in(as_bus), .mem_dq_out(as_dout),
		.mem_dq_oe(as_oe));
	lasp_sram_model lasp_sram_model_async_inst (.addr(as_addr), .chip_en_n(as_ce_n), .out_en_n(as_oe_n),
		.addr_capture(as_acap), .din_capture(as_dcap), .lower_byte_wr_n(as_lo_n), .upper_byte_wr_n(as_up_n),
		.dq_in(as_bus), .dq_out(as_q), .dq_drive(as_drv));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// One access; inputs change at falling edges, held until taken
	task automatic access(input logic w, input logic [15:0] a, input logic [17:0] d,
		input logic [1:0] be, output logic [17:0] q);
		int n;
		n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_byte_en = be;
		while (req_ready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n >= 20) check("req_ready", 18'h0, 18'h1);
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		if (n >= 10) check("rsp_valid", 18'h0, 18'h1);
		check("async_rsp", as_rsp, 1'b1);
		q = rsp_rdata;
	endtask
	// Pin protocol monitor, sampled where outputs are settled
	always @(negedge clk) begin
		if (nrst) begin
			if (!oe_n) check("read_strobes", {lo_wr_n, up_wr_n}, 2'h3);
			if (mem_addr !== p_addr) check("addr_move_strobes", {lo_wr_n, up_wr_n}, 2'h3);
			if (!ce_n && p_ce) check("addr_at_ce_fall", mem_addr, p_addr);
			if (!p_acap && !acap) check("addr_held", {ce_n, mem_addr}, {p_ce, p_addr});
			if (!p_dcap && !dcap) check("data_held", dq_out, p_dq);
			if (!p_dcap && !dcap) check("data_held_oe", dq_oe, 1'b1);
			check("async_captures", {as_acap, as_dcap}, 2'h3);
		end
		{p_addr, p_ce, p_acap, p_dcap, p_dq} = {mem_addr, ce_n, acap, dcap, dq_out};
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		check("dq_oe_rst", dq_oe, 1'b0);
		check("sram_drive_rst", drv, 1'b0);
		check("ce_rst", ce_n, 1'b1);
		check("ready_rst", req_ready, 1'b0);
	endtask
	// Reset in mid-access parks the pins and loses nothing stored
	task automatic t_mid_reset();
		@(negedge clk);
		req_valid = 1'b1;
		req_write = 1'b1;
		req_addr = 16'h1234;
		req_wdata = 18'h0;
		req_byte_en = 2'h3;
		@(negedge clk);
		req_valid = 1'b0;
		@(negedge clk);
		nrst = 1'b0;
		#1;
		check("mid_ce", ce_n, 1'b1);
		check("mid_strobes", {lo_wr_n, up_wr_n}, 2'h3);
		check("mid_float", dq_oe, 1'b0);
		@(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		check("ready_after_rst", req_ready, 1'b1);
		access(1'b0, 16'h1234, 18'h0, 2'h0, rd);
		check("kept_over_rst", rd, 18'h2a5a5);
		check("async_kept_over_rst", as_rdata, 18'h2a5a5);
	endtask
	task automatic t_word();
		access(1'b1, 16'h1234, 18'h2a5a5, 2'h3, rd);
		access(1'b1, 16'hffff, 18'h15a5a, 2'h3, rd);
		access(1'b0, 16'h1234, 18'h0, 2'h0, rd);
		check("word_rd", rd, 18'h2a5a5);
		check("async_word_rd", as_rdata, 18'h2a5a5);
		access(1'b0, 16'hffff, 18'h0, 2'h0, rd);
		check("word_top_rd", rd, 18'h15a5a);
		check("async_top_rd", as_rdata, 18'h15a5a);
		check("idle_float", drv, 1'b0);
	endtask
	task automatic t_bytes();
		access(1'b1, 16'h0040, 18'h3ffff, 2'h3, rd);
		access(1'b1, 16'h0040, 18'h0, 2'h1, rd);
		access(1'b0, 16'h0040, 18'h0, 2'h0, rd);
		check("lower_only", rd, 18'h3fe00);
		check("async_lower_only", as_rdata, 18'h3fe00);
		access(1'b1, 16'h0040, 18'h0, 2'h2, rd);
		access(1'b1, 16'h0040, 18'h3ffff, 2'h0, rd);
		access(1'b0, 16'h0040, 18'h0, 2'h0, rd);
		check("upper_then_none", rd, 18'h0);
		check("async_upper_then_none", as_rdata, 18'h0);
		access(1'b0, 16'h1234, 18'h0, 2'h0, rd);
		check("neighbour_kept", rd, 18'h2a5a5);
	endtask
	// Hang guard, far beyond the fewer than a hundred cycles used
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (3) @(negedge clk);
		t_reset();
		nrst = 1'b1;
		t_word();
		t_bytes();
		t_mid_reset();
		end_of_test();
	end
endmodule
